// ### rtl/acam_monitor.sv
`timescale 1ns/1ps
`include "acam_defs.svh"

// Summary of operation
// - Alarm pin updates on sixteenth SCLK fall.
// - Alarm pin high when any flag tripped.
// - Per-main-channel high/low thresholds, each with hysteresis.
// - High sets above threshold plus hysteresis.
// - High clears at threshold minus hysteresis minus two.
// - Low sets below threshold minus hysteresis minus one.
// - Low clears at threshold plus hysteresis plus one.
// - Active flag follows the alarm condition.
// - Tripped flag latches until its register read.
// - Straight binary codes on every channel.
// - Main results are eighteen bits wide.
// - Five selectable input ranges per main channel.
// - Auxiliary channel gives sixteen-bit unipolar results.
// - Chip select fall starts frame and conversion.
module acam_monitor import acam_pkg::*; (
  input  wire logic        clock,
  input  wire logic        rst_b,
  input  wire logic        hsel,
  input  wire logic [31:0] haddr,
  input  wire logic [1:0]  htrans,
  input  wire logic        hwrite,
  input  wire logic [2:0]  hsize,
  input  wire logic [31:0] hwdata,
  input  wire logic        hready,
  output logic             hreadyout,
  output logic             hresp,
  output logic [31:0]      hrdata,
  input  wire logic        sclkPin,
  input  wire logic        csPinB,
  output logic             alarmPin,
  output logic             irq,
  output acam_conv_type    convReq,
  input  wire logic        resultValid,
  input  wire logic [17:0] resultCode
);

  acam_aphase_type apNow;
  acam_aphase_type ap_reg;
  acam_conv_type   convReq_reg;

  logic [3:0]  chanNext_reg;
  logic [3:0]  chanCur_reg;
  logic [23:0] rangeCfg_reg;
  logic [17:0] result_reg;
  logic [3:0]  resultChan_reg;
  logic [15:0] tripped_reg;
  logic [15:0] tripped_next;
  logic [1:0]  intStat_reg;
  logic [1:0]  intStat_next;
  logic [1:0]  intMask_reg;
  logic        alarmPin_reg;
  logic [31:0] hrdata_reg;

  logic        frameStart;
  logic        edge16;
  logic [7:0]  hiActive;
  logic [7:0]  loActive;
  logic [7:0]  hiSet;
  logic [7:0]  loSet;
  logic [15:0] tripSet;
  logic [15:0] activeWord;
  logic [31:0] chWord [`ACAM_NCH];
  logic        isMain;
  logic        mainUpdate;
  logic [17:0] codeIn;
  logic [2:0]  curRangeRaw;
  logic        wrEn;
  logic        wrCtrl;
  logic        wrRange;
  logic        wrIntStat;
  logic        wrIntMask;
  logic        wrChBlock;
  logic        rdTripped;
  logic        nowChBlock;
  logic [2:0]  nowCh;
  logic [1:0]  nowField;
  logic [31:0] rdMux;

  // Bus slave: zero wait states, always OKAY.
  assign hreadyout = 1'b1;
  assign hresp     = 1'b0;
  assign hrdata    = hrdata_reg;

  assign apNow.valid = hsel & htrans[1] & hready;
  assign apNow.write = hwrite;
  assign apNow.addr  = {haddr[11:2], 2'b00};

  assign wrEn      = ap_reg.valid & ap_reg.write;
  assign wrCtrl    = wrEn & (ap_reg.addr == `ACAM_CTRL_OFS);
  assign wrRange   = wrEn & (ap_reg.addr == `ACAM_RANGE_OFS);
  assign wrIntStat = wrEn & (ap_reg.addr == `ACAM_INT_STAT_OFS);
  assign wrIntMask = wrEn & (ap_reg.addr == `ACAM_INT_MASK_OFS);
  assign wrChBlock = wrEn & (ap_reg.addr[11:7] == `ACAM_CH_BLOCK);

  assign rdTripped = apNow.valid & ~apNow.write &
                     (apNow.addr == `ACAM_TRIPPED_OFS);

  assign nowChBlock = apNow.addr[11:7] == `ACAM_CH_BLOCK;
  assign nowCh      = apNow.addr[6:4];
  assign nowField   = apNow.addr[3:2];

  assign activeWord = {hiActive, loActive};

  assign rdMux =
    (apNow.addr == `ACAM_CTRL_OFS)     ? {28'h0000000, chanNext_reg} :
    (apNow.addr == `ACAM_RANGE_OFS)    ? {8'h00, rangeCfg_reg} :
    (apNow.addr == `ACAM_RESULT_OFS)   ? {8'h00, resultChan_reg, 2'b00, result_reg} :
    (apNow.addr == `ACAM_ACTIVE_OFS)   ? {16'h0000, activeWord} :
    (apNow.addr == `ACAM_TRIPPED_OFS)  ? {16'h0000, tripped_reg} :
    (apNow.addr == `ACAM_INT_STAT_OFS) ? {30'h00000000, intStat_reg} :
    (apNow.addr == `ACAM_INT_MASK_OFS) ? {30'h00000000, intMask_reg} :
    nowChBlock                         ? chWord[nowCh] :
                                         32'h00000000;

  always_ff @(posedge clock) begin
    if (!rst_b) begin
      ap_reg     <= '0;
      hrdata_reg <= 32'h00000000;
    end else begin
      ap_reg <= apNow;
      if (apNow.valid && !apNow.write) begin
        hrdata_reg <= rdMux;
      end
    end
  end

  // Link pins.
  acam_link_sync u_link (
    .clock      (clock),
    .rst_b      (rst_b),
    .sclkPin    (sclkPin),
    .csPinB     (csPinB),
    .frameStart (frameStart),
    .edge16     (edge16)
  );

  assign curRangeRaw = rangeCfg_reg[3 * chanNext_reg[2:0] +: 3];

  always_ff @(posedge clock) begin
    if (!rst_b) begin
      chanNext_reg <= `ACAM_CHAN_RST;
      chanCur_reg  <= `ACAM_CHAN_RST;
      rangeCfg_reg <= `ACAM_RANGE_RST;
      convReq_reg  <= '0;
    end else begin
      if (wrCtrl && hwdata[3:0] <= `ACAM_AUX_CH) begin
        chanNext_reg <= hwdata[3:0];
      end
      if (wrRange) begin
        rangeCfg_reg <= hwdata[23:0];
      end
      convReq_reg.start <= frameStart;
      if (frameStart) begin
        chanCur_reg       <= chanNext_reg;
        convReq_reg.chan  <= chanNext_reg;
        if (chanNext_reg == `ACAM_AUX_CH) begin
          convReq_reg.range <= ACAM_UNI_VREF;
        end else begin
          convReq_reg.range <= acam_range_type'(curRangeRaw);
        end
      end
    end
  end

  assign convReq = convReq_reg;

  assign codeIn = (chanCur_reg == `ACAM_AUX_CH) ? {2'b00, resultCode[15:0]} : resultCode;
  assign isMain = chanCur_reg != `ACAM_AUX_CH;
  assign mainUpdate = resultValid & isMain;

  always_ff @(posedge clock) begin
    if (!rst_b) begin
      result_reg     <= 18'h00000;
      resultChan_reg <= `ACAM_CHAN_RST;
    end else if (resultValid) begin
      result_reg     <= codeIn;
      resultChan_reg <= chanCur_reg;
    end
  end

  genvar ch;
  generate
    for (ch = 0; ch < `ACAM_NCH; ch = ch + 1) begin : g_ch
      acam_chcfg_type cfg_reg;
      logic           chUpdate;
      logic           chWrite;

      assign chWrite  = wrChBlock & (ap_reg.addr[6:4] == 3'(ch));
      assign chUpdate = mainUpdate & (chanCur_reg[2:0] == 3'(ch));

      assign chWord[ch] =
        (nowField == `ACAM_F_HI_THR)  ? {14'h0000, cfg_reg.hiThr} :
        (nowField == `ACAM_F_HI_HYST) ? {14'h0000, cfg_reg.hiHyst} :
        (nowField == `ACAM_F_LO_THR)  ? {14'h0000, cfg_reg.loThr} :
                                        {14'h0000, cfg_reg.loHyst};

      always_ff @(posedge clock) begin
        if (!rst_b) begin
          cfg_reg.hiThr  <= `ACAM_HI_THR_RST;
          cfg_reg.hiHyst <= `ACAM_HYST_RST;
          cfg_reg.loThr  <= `ACAM_LO_THR_RST;
          cfg_reg.loHyst <= `ACAM_HYST_RST;
        end else if (chWrite) begin
          if (ap_reg.addr[3:2] == `ACAM_F_HI_THR) begin
            cfg_reg.hiThr <= hwdata[17:0];
          end
          if (ap_reg.addr[3:2] == `ACAM_F_HI_HYST) begin
            cfg_reg.hiHyst <= hwdata[17:0];
          end
          if (ap_reg.addr[3:2] == `ACAM_F_LO_THR) begin
            cfg_reg.loThr <= hwdata[17:0];
          end
          if (ap_reg.addr[3:2] == `ACAM_F_LO_HYST) begin
            cfg_reg.loHyst <= hwdata[17:0];
          end
        end
      end

      acam_alarm_chan u_alarm (
        .clock        (clock),
        .rst_b        (rst_b),
        .update       (chUpdate),
        .code         (codeIn),
        .cfg          (cfg_reg),
        .hiActive_reg (hiActive[ch]),
        .loActive_reg (loActive[ch]),
        .hiSet        (hiSet[ch]),
        .loSet        (loSet[ch])
      );
    end
  endgenerate

  assign tripSet      = {hiSet, loSet};
  assign tripped_next = (rdTripped ? 16'h0000 : tripped_reg) | tripSet;

  // Sticky interrupt causes; a new event beats a same-cycle clear.
  assign intStat_next = (wrIntStat ? (intStat_reg & ~hwdata[1:0]) : intStat_reg) |
                        {|tripSet, resultValid};

  always_ff @(posedge clock) begin
    if (!rst_b) begin
      tripped_reg <= 16'h0000;
      intStat_reg <= 2'h0;
      intMask_reg <= 2'h0;
    end else begin
      tripped_reg <= tripped_next;
      intStat_reg <= intStat_next;
      if (wrIntMask) begin
        intMask_reg <= hwdata[1:0];
      end
    end
  end

  assign irq = |(intStat_reg & intMask_reg);

  always_ff @(posedge clock) begin
    if (!rst_b) begin
      alarmPin_reg <= 1'b0;
    end else if (edge16) begin
      alarmPin_reg <= |tripped_reg;
    end
  end

  assign alarmPin = alarmPin_reg;

endmodule // acam_monitor

// ### rtl/acam_defs.svh
`ifndef ACAM_DEFS_SVH
`define ACAM_DEFS_SVH

// Register byte offsets within the 4 KiB slave window.
`define ACAM_CTRL_OFS      12'h000
`define ACAM_RANGE_OFS     12'h004
`define ACAM_RESULT_OFS    12'h008
`define ACAM_ACTIVE_OFS    12'h00c
`define ACAM_TRIPPED_OFS   12'h010
`define ACAM_INT_STAT_OFS  12'h014
`define ACAM_INT_MASK_OFS  12'h018
// Channel threshold block: 0x080 + 0x10 * channel + 0x4 * field.
`define ACAM_CH_BLOCK      5'h01
`define ACAM_F_HI_THR      2'h0
`define ACAM_F_HI_HYST     2'h1
`define ACAM_F_LO_THR      2'h2
`define ACAM_F_LO_HYST     2'h3

`define ACAM_NCH           8
`define ACAM_AUX_CH        4'h8
`define ACAM_ALARM_EDGE    5'h10
`define ACAM_HI_GAP        20'h00002
`define ACAM_LO_GAP        20'h00001

`define ACAM_INT_CONV      0
`define ACAM_INT_TRIP      1

`define ACAM_HI_THR_RST    18'h3ffff
`define ACAM_LO_THR_RST    18'h00000
`define ACAM_HYST_RST      18'h00000
`define ACAM_RANGE_RST     24'h000000
`define ACAM_CHAN_RST      4'h0

`endif

// ### rtl/acam_pkg.sv
package acam_pkg;

  typedef enum logic [2:0] {
    ACAM_BI_10V24 = 3'h0,
    ACAM_BI_5V12  = 3'h1,
    ACAM_BI_2V56  = 3'h2,
    ACAM_UNI_10V24 = 3'h5,
    ACAM_UNI_5V12 = 3'h6,
    ACAM_UNI_VREF = 3'h7
  } acam_range_type;

  typedef struct packed {
    logic [17:0] hiThr;
    logic [17:0] hiHyst;
    logic [17:0] loThr;
    logic [17:0] loHyst;
  } acam_chcfg_type;

  typedef struct packed {
    logic           start;
    logic [3:0]     chan;
    acam_range_type range;
  } acam_conv_type;

  typedef struct packed {
    logic        valid;
    logic        write;
    logic [11:0] addr;
  } acam_aphase_type;

endpackage

// ### rtl/acam_link_sync.sv
`timescale 1ns/1ps
`include "acam_defs.svh"

// Samples the serial link pins on the system clock and marks frame events.
module acam_link_sync import acam_pkg::*; (
  input  wire logic clock,
  input  wire logic rst_b,
  input  wire logic sclkPin,
  input  wire logic csPinB,
  output logic      frameStart,
  output logic      edge16
);

  logic [1:0] sclkSync_reg;
  logic [1:0] csSync_reg;
  logic       sclkLast_reg;
  logic       csLast_reg;
  logic [4:0] fallCount_reg;
  logic [4:0] fallCount_next;
  logic       sclkFall;

  assign sclkFall   = sclkLast_reg & ~sclkSync_reg[1];
  assign frameStart = csLast_reg & ~csSync_reg[1];
  assign edge16     = sclkFall & ~csSync_reg[1] &
                      (fallCount_next == `ACAM_ALARM_EDGE);
  assign fallCount_next = fallCount_reg + 5'h01;

  always_ff @(posedge clock) begin
    if (!rst_b) begin
      sclkSync_reg  <= 2'h0;
      csSync_reg    <= 2'h3;
      sclkLast_reg  <= 1'b0;
      csLast_reg    <= 1'b1;
      fallCount_reg <= 5'h00;
    end else begin
      sclkSync_reg <= {sclkSync_reg[0], sclkPin};
      csSync_reg   <= {csSync_reg[0], csPinB};
      sclkLast_reg <= sclkSync_reg[1];
      csLast_reg   <= csSync_reg[1];
      if (csSync_reg[1]) begin
        fallCount_reg <= 5'h00;
      end else if (sclkFall && fallCount_reg != `ACAM_ALARM_EDGE) begin
        fallCount_reg <= fallCount_next;
      end
    end
  end

endmodule // acam_link_sync

// ### rtl/acam_alarm_chan.sv
`timescale 1ns/1ps
`include "acam_defs.svh"

// High and low alarm with hysteresis for one channel.
module acam_alarm_chan import acam_pkg::*; (
  input  wire logic           clock,
  input  wire logic           rst_b,
  input  wire logic           update,
  input  wire logic [17:0]    code,
  input  acam_chcfg_type      cfg,
  output logic                hiActive_reg,
  output logic                loActive_reg,
  output logic                hiSet,
  output logic                loSet
);

  logic signed [19:0] codeS;
  logic signed [19:0] hiUpper;
  logic signed [19:0] hiLower;
  logic signed [19:0] loLower;
  logic signed [19:0] loUpper;
  logic               hiClr;
  logic               loClr;

  assign codeS   = {2'b00, code};
  assign hiUpper = {2'b00, cfg.hiThr} + {2'b00, cfg.hiHyst};
  assign hiLower = {2'b00, cfg.hiThr} - {2'b00, cfg.hiHyst} - `ACAM_HI_GAP;
  assign loLower = {2'b00, cfg.loThr} - {2'b00, cfg.loHyst} - `ACAM_LO_GAP;
  assign loUpper = {2'b00, cfg.loThr} + {2'b00, cfg.loHyst} + `ACAM_LO_GAP;

  assign hiSet = update & ~hiActive_reg & (codeS > hiUpper);
  assign hiClr = update & hiActive_reg & (codeS <= hiLower);
  assign loSet = update & ~loActive_reg & (codeS < loLower);
  assign loClr = update & loActive_reg & (codeS >= loUpper);

  always_ff @(posedge clock) begin
    if (!rst_b) begin
      hiActive_reg <= 1'b0;
      loActive_reg <= 1'b0;
    end else begin
      if (hiSet) begin
        hiActive_reg <= 1'b1;
      end else if (hiClr) begin
        hiActive_reg <= 1'b0;
      end
      if (loSet) begin
        loActive_reg <= 1'b1;
      end else if (loClr) begin
        loActive_reg <= 1'b0;
      end
    end
  end

endmodule // acam_alarm_chan

// ### tb/acam_monitor_chk.sv
`timescale 1ns/1ps
module acam_monitor_chk import acam_pkg::*; (
  input  wire logic        clock,
  input  wire logic        rst_b,
  input  wire logic        csPinB,
  input  wire logic        alarmPin,
  input  wire logic        hreadyout,
  input  wire logic        hresp,
  input  acam_conv_type    convReq
);
  default clocking @(posedge clock); endclocking
  default disable iff (!rst_b);
  a_zero_wait: assert property (hreadyout)
    else $error("hreadyout low");
  a_resp_okay: assert property (!hresp)
    else $error("hresp not OKAY");
  a_alarm_in_frame: assert property ($changed(alarmPin) |-> !$past(csPinB, 4))
    else $error("alarm moved outside a frame");
  a_start_pulse: assert property (convReq.start |=> !convReq.start [*8])
    else $error("start longer than one cycle");
  a_start_cause: assert property (convReq.start |-> !csPinB && $past(csPinB, 6))
    else $error("start without chip select fall");
  a_chan_legal: assert property (convReq.start |-> convReq.chan <= 4'h8)
    else $error("channel out of range");
  a_aux_range: assert property (convReq.start && convReq.chan == 4'h8 |->
    convReq.range == ACAM_UNI_VREF) else $error("aux range wrong");
  a_main_range: assert property (convReq.start && convReq.chan < 4'h8 |->
    convReq.range != ACAM_UNI_VREF) else $error("main range wrong");
endmodule // acam_monitor_chk

bind acam_monitor acam_monitor_chk acam_monitor_chk_i (.clock(clock), .rst_b(rst_b),
  .csPinB(csPinB), .alarmPin(alarmPin), .hreadyout(hreadyout), .hresp(hresp),
  .convReq(convReq));

// ### tb/acam_host_model.sv
`timescale 1ns/1ps
// Host framing on the serial pins plus the converter that answers each start.
module acam_host_model import acam_pkg::*; (
  input  wire logic        clock,
  input  acam_conv_type    convReq,
  input  wire logic [17:0] nextCode,
  input  wire logic [5:0]  convWait,
  output logic             sclkPin,
  output logic             csPinB,
  output logic             resultValid,
  output logic [17:0]      resultCode
);
  initial begin
    sclkPin = 1'b0;
    csPinB = 1'b1;
    resultValid = 1'b0;
    resultCode = 18'h15555;
  end
  // frame opens on chip select fall
  task automatic frame();
    #3 csPinB = 1'b0;
    #203;
    repeat (20) begin
      #80 sclkPin = 1'b1;
      #80 sclkPin = 1'b0;
    end
    #100 csPinB = 1'b1;
    #300;
  endtask
  // The code is only valid in the pulse cycle; after it, it shows its inverse until the next pulse.
  always @(posedge clock) begin
    if (convReq.start) begin
      repeat (convWait) @(posedge clock);
      resultValid <= 1'b1;
      resultCode <= nextCode;
      @(posedge clock);
      resultValid <= 1'b0;
      resultCode <= ~nextCode;
    end
  end
endmodule // acam_host_model

// ### tb/test_adc_code_alarm_monitor.sv
`timescale 1ns/1ps
module test_adc_code_alarm_monitor import acam_pkg::*; ;
  logic          clock, rst_b, hsel, hwrite, hreadyout, hresp, alarmPin, irq;
  logic          sclkPin, csPinB, resultValid;
  logic [31:0]   haddr, hwdata, hrdata, rdata;
  logic [1:0]    htrans;
  logic [17:0]   nextCode, resultCode;
  logic [5:0]    convWait;
  logic [7:0]    hiAct, loAct;
  logic [2:0]    seenRange;
  logic [23:0]   rangeReg;
  logic [3:0]    ch;
  logic [11:0]   b;
  acam_conv_type convReq;
  int            seed = 72092;
  int            numErrors = 0;
  int            totalChecks = 0;
  int            T, H, L, G;
  int            cs[$];
  acam_range_type rt [5] = '{ACAM_BI_10V24, ACAM_BI_5V12, ACAM_BI_2V56, ACAM_UNI_10V24,
    ACAM_UNI_5V12};

  acam_monitor acam_monitor_i (.clock(clock), .rst_b(rst_b), .hsel(hsel), .haddr(haddr),
    .htrans(htrans), .hwrite(hwrite), .hsize(3'h2), .hwdata(hwdata), .hready(hreadyout),
    .hreadyout(hreadyout), .hresp(hresp), .hrdata(hrdata), .sclkPin(sclkPin),
    .csPinB(csPinB), .alarmPin(alarmPin), .irq(irq), .convReq(convReq),
    .resultValid(resultValid), .resultCode(resultCode));
  acam_host_model acam_host_model_i (.clock(clock), .convReq(convReq), .nextCode(nextCode),
    .convWait(convWait), .sclkPin(sclkPin), .csPinB(csPinB), .resultValid(resultValid),
    .resultCode(resultCode));

  initial begin
    clock = 1'b0;
    forever #4 clock = ~clock;
  end
  always @(posedge clock) if (convReq.start) seenRange <= convReq.range;

  task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
    totalChecks++;
    if (seen !== exp) begin
      numErrors++;
      $display("ERROR %s expected %h seen %h", what, exp, seen);
    end
  endtask

  task automatic bus(input logic wr, input logic [11:0] a, input logic [31:0] wd);
    @(posedge clock);
    hsel <= 1'b1;
    htrans <= 2'h2;
    hwrite <= wr;
    haddr <= {20'h0, a};
    do @(posedge clock); while (hreadyout !== 1'b1);
    hsel <= 1'b0;
    htrans <= 2'h0;
    hwdata <= wd;
    do @(posedge clock); while (hreadyout !== 1'b1);
    rdata = hrdata;
  endtask

  task automatic frame(input logic [3:0] c4, input int c);
    logic hs, ls;
    hs = (c4 < 8) && (c > T + H);
    ls = (c4 < 8) && (c < L - G - 1);
    if (c4 < 8) begin
      hiAct[c4] = hs | (hiAct[c4] & !(c <= T - H - 2));
      loAct[c4] = ls | (loAct[c4] & !(c >= L + G + 1));
    end
    bus(1'b1, 12'h000, {28'h0, c4});
    nextCode <= c[17:0];
    convWait <= 6'($random(seed));
    acam_host_model_i.frame();
    check("alarmPin", {31'h0, alarmPin}, {31'h0, hs | ls});
    check("range", {29'h0, seenRange}, {29'h0, c4 < 8 ? rangeReg[3*c4+:3] : 3'h7});
    bus(1'b0, 12'h00c, 32'h0);
    check("active", rdata, {16'h0, hiAct, loAct});
    bus(1'b0, 12'h010, 32'h0);
    check("tripped", rdata, {16'h0, 8'(hs) << c4, 8'(ls) << c4});
    bus(1'b0, 12'h010, 32'h0);
    check("cleared", rdata, 32'h0);
  endtask

  task automatic reportAndStop();
    $display("checks %0d errors %0d", totalChecks, numErrors);
    if (numErrors == 0 && totalChecks > 0) $display("TEST PASSED");
    else $display("TEST FAILED");
    $finish;
  endtask

  initial begin
    #600000;
    numErrors++;
    reportAndStop();
  end

  initial begin
    {hsel, hwrite, htrans, haddr, hwdata, nextCode, convWait, hiAct, loAct} = '0;
    T = 'h3ffff;
    {H, L, G} = '0;
    rst_b = 1'b0;
    repeat (3) @(posedge clock);
    rst_b <= 1'b1;
    bus(1'b0, 12'h080, 32'h0);
    check("hiThrReset", rdata, 32'h3ffff);
    bus(1'b0, 12'h040, 32'h0);
    check("unmapped", rdata, 32'h0);
    bus(1'b1, 12'h018, 32'h3);
    // Each of the five main range codes, on channels 0 to 4 left at their reset thresholds.
    for (int k = 0; k < 5; k++) begin
      rangeReg = {8{rt[k]}};
      bus(1'b1, 12'h004, {8'h0, rangeReg});
      frame(4'(k), 'h20000 + k);
      bus(1'b0, 12'h008, 32'h0);
      check("result", rdata, {8'h0, 4'(k), 2'h0, 18'('h20000 + k)});
    end
    bus(1'b0, 12'h014, 32'h0);
    check("intDone", {31'h0, rdata[0]}, 32'h1);
    check("irqHigh", {31'h0, irq}, 32'h1);
    bus(1'b1, 12'h014, 32'h3);
    bus(1'b0, 12'h014, 32'h0);
    check("irqCleared", {31'h0, irq}, 32'h0);
    for (int r = 0; r < 4; r++) begin
      ch = 4'($random(seed) & 7);
      T = 'h20000 + ($random(seed) & 'hffff);
      H = $random(seed) & 15;
      L = 1000 + ($random(seed) & 1023);
      G = $random(seed) & 15;
      b = 12'h080 + {4'h0, ch, 4'h0};
      bus(1'b1, b, 32'(T));
      bus(1'b1, b + 12'h4, 32'(H));
      bus(1'b1, b + 12'h8, 32'(L));
      bus(1'b1, b + 12'hc, 32'(G));
      cs = '{T+H+1, T+H, T-H-1, T-H-2, T+H, T+H+1, T-H-2,
        L-G-2, L+G, L+G+1, L-G-1, L-G-2, L+G+1};
      foreach (cs[i]) frame(ch, cs[i]);
    end
    bus(1'b1, 12'h018, 32'h0);
    bus(1'b1, 12'h014, 32'h3);
    frame(4'h8, $random(seed) & 'hffff);
    check("irqMasked", {31'h0, irq}, 32'h0);
    bus(1'b1, 12'h018, 32'h1);
    bus(1'b0, 12'h014, 32'h0);
    check("irqUnmasked", {31'h0, irq}, 32'h1);
    reportAndStop();
  end
endmodule // test_adc_code_alarm_monitor
